// file: rtl/dpsl_cfg.svh
// Purpose: constants for the digipot serial latch control block
// Assumes: one or two wiper channels, eight code bits each
// Notes: timing of the host clock divider is a count of mclk cycles
`ifndef DPSL_CFG_SVH
`define DPSL_CFG_SVH
`define DPSL_CODE_W      8
`define DPSL_MIDSCALE    8'h80
`define DPSL_TAPS        256
`define DPSL_SEL_POS     8
`define DPSL_CH0         1'h0
`define DPSL_CH1         1'h1
`define DPSL_MCLK_MHZ    50
`define DPSL_SCK_NS      200
`define DPSL_HALF_CYC    ((`DPSL_SCK_NS * `DPSL_MCLK_MHZ) / 2000)
`endif

// file: rtl/dpsl_pkg.sv
package dpsl_pkg;
   typedef enum logic [1:0] {DPSL_IDLE, DPSL_LOW, DPSL_HIGH, DPSL_DONE} dpsl_hst_t;
endpackage : dpsl_pkg

// file: rtl/dpsl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dpsl_if;
   logic sck;
   logic cs_n;
   logic serial_data_in;
   logic midscale_preset_n;
   logic power_down_n;
   logic chain_pd_en;
   logic chain_data_out;
   // open-drain wire with pull-up
   assign chain_data_out = ~chain_pd_en;
   modport dev (input sck, input cs_n, input serial_data_in, input midscale_preset_n,
                input power_down_n, output chain_pd_en);
   modport hst (output sck, output cs_n, output serial_data_in, output midscale_preset_n,
                output power_down_n, input chain_data_out);
endinterface : dpsl_if
`default_nettype wire

// file: rtl/dpsl_dev.sv
// Purpose: device end: shift register, wiper latches, chain output
// Assumes: clocked by link sck; cs rise loads via a clock held by the link
// Notes: latches are written on cs rising edge, preset is asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "dpsl_cfg.svh"
module dpsl_dev #(
   parameter int CHANNELS = 2
) (
   dpsl_if.dev                      lnk,
   input  wire logic                 por_n,
   output logic [`DPSL_CODE_W-1:0]   wiper_latch0,
   output logic [`DPSL_CODE_W-1:0]   wiper_latch1,
   output logic [`DPSL_TAPS-1:0]     tap_sel0,
   output logic [`DPSL_TAPS-1:0]     tap_sel1,
   output logic                      a_open,
   output logic                      wiper_to_b
);
   localparam int SRW = (CHANNELS == 2) ? `DPSL_CODE_W + 1 : `DPSL_CODE_W;
   initial begin
      if (CHANNELS != 1 && CHANNELS != 2) $error("dpsl_dev: CHANNELS must be 1 or 2");
   end

   logic [SRW-1:0]          serial_shift_register;
   logic                    out_latch_q;
   logic                    rst_all_n;
   logic                    channel_select_bit;
   logic [`DPSL_CODE_W-1:0] new_code;

   function automatic logic [`DPSL_TAPS-1:0] dpsl_tap(input logic [`DPSL_CODE_W-1:0] c);
      dpsl_tap    = '0;
      dpsl_tap[c] = 1'b1;
   endfunction : dpsl_tap

   assign rst_all_n          = lnk.midscale_preset_n & por_n;
   assign channel_select_bit = (CHANNELS == 2) ? serial_shift_register[SRW-1] : `DPSL_CH0;
   assign new_code           = serial_shift_register[`DPSL_CODE_W-1:0];

   // shift on sck rise while selected; preset clears output latch
   always_ff @(posedge lnk.sck or negedge rst_all_n) begin
      if (!rst_all_n) begin
         serial_shift_register <= '0;
         out_latch_q           <= 1'b0;
      end else if (!lnk.cs_n) begin
         serial_shift_register <= {serial_shift_register[SRW-2:0], lnk.serial_data_in};
         out_latch_q           <= serial_shift_register[`DPSL_CODE_W-1];
      end
   end

   // cs rising edge loads the selected latch; shutdown blocks the load
   always_ff @(posedge lnk.cs_n or negedge rst_all_n) begin
      if (!rst_all_n) begin
         wiper_latch0 <= `DPSL_MIDSCALE;
         wiper_latch1 <= `DPSL_MIDSCALE;
      end else if (lnk.power_down_n) begin
         if (channel_select_bit == `DPSL_CH0) begin
            wiper_latch0 <= new_code;
         end else begin
            wiper_latch1 <= new_code;
         end
      end
   end

   // shutdown leaves latches alone, steers the analog switches and also releases the chain output
   assign a_open     = ~lnk.power_down_n;
   assign wiper_to_b = ~lnk.power_down_n;
   assign tap_sel0   = dpsl_tap(wiper_latch0);
   assign tap_sel1   = dpsl_tap(wiper_latch1);
   // pull low only when driving a zero, selected, powered
   assign lnk.chain_pd_en = ~out_latch_q & ~lnk.cs_n & lnk.power_down_n & rst_all_n;
endmodule : dpsl_dev
`default_nettype wire

// file: rtl/dpsl_hst.sv
// Purpose: host end: sends chained words over the serial link
// Assumes: sck made from mclk by a divider, so no second domain here
// Notes: nbits counts total bits; word is sent msb first
`timescale 1ns/1ps
`default_nettype none
`include "dpsl_cfg.svh"
module dpsl_hst #(
   parameter int MAXB = 18,
   parameter int HALF = `DPSL_HALF_CYC
) (
   input  wire logic            mclk,
   input  wire logic            rst_n,
   input  wire logic            ce,
   dpsl_if.hst                  lnk,
   input  wire logic            start,
   input  wire logic [MAXB-1:0] word,
   input  wire logic [4:0]      nbits,
   input  wire logic            preset_req_n,
   input  wire logic            shutdown_req_n,
   output logic                 busy,
   output logic                 done,
   output logic [MAXB-1:0]      rx_word
);
   initial begin
      if (HALF < 1 || MAXB < 1 || MAXB > 31) $error("dpsl_hst: bad parameter");
   end
   dpsl_pkg::dpsl_hst_t st_q;
   logic [MAXB-1:0]     sh_q;
   logic [4:0]          cnt_q;
   logic [15:0]         div_q;
   logic                sdo_s1_q;
   logic                sdo_s2_q;
   logic                sck_q;
   logic                cs_n_q;
   logic                sdi_q;
   logic                pr_q;
   logic                sd_q;
   logic                tick;
   logic [MAXB-1:0]     aligned;

   // word moved to the top so the first bit sent is its msb
   assign aligned = MAXB'(word << (MAXB - int'(nbits)));
   assign tick = (div_q == 16'(HALF - 1));
   assign lnk.sck               = sck_q;
   assign lnk.cs_n              = cs_n_q;
   assign lnk.serial_data_in    = sdi_q;
   assign lnk.midscale_preset_n = pr_q;
   assign lnk.power_down_n      = sd_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sdo_s1_q <= 1'b1;
         sdo_s2_q <= 1'b1;
         pr_q     <= 1'b1;
         sd_q     <= 1'b1;
      end else if (ce) begin
         sdo_s1_q <= lnk.chain_data_out;
         sdo_s2_q <= sdo_s1_q;
         pr_q     <= preset_req_n;
         sd_q     <= shutdown_req_n;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_q    <= dpsl_pkg::DPSL_IDLE;
         sh_q    <= '0;
         cnt_q   <= '0;
         div_q   <= '0;
         sck_q   <= 1'b0;
         cs_n_q  <= 1'b1;
         sdi_q   <= 1'b0;
         busy    <= 1'b0;
         done    <= 1'b0;
         rx_word <= '0;
      end else if (ce) begin
         done  <= 1'b0;
         div_q <= tick ? '0 : div_q + 16'h0001;
         case (st_q)
            dpsl_pkg::DPSL_IDLE: begin
               div_q <= '0;
               if (start && nbits != 5'h00) begin
                  // first bit set up half a period before the first rise
                  sdi_q  <= aligned[MAXB-1];
                  sh_q   <= {aligned[MAXB-2:0], 1'b0};
                  cnt_q  <= nbits;
                  cs_n_q <= 1'b0;
                  busy   <= 1'b1;
                  st_q   <= dpsl_pkg::DPSL_LOW;
               end
            end
            dpsl_pkg::DPSL_LOW: if (tick) begin
               sck_q <= 1'b1;
               cnt_q <= cnt_q - 5'h01;
               st_q  <= dpsl_pkg::DPSL_HIGH;
            end
            dpsl_pkg::DPSL_HIGH: if (tick) begin
               // data changes on the falling edge, away from the device's sampling edge
               sck_q   <= 1'b0;
               sdi_q   <= sh_q[MAXB-1];
               sh_q    <= {sh_q[MAXB-2:0], 1'b0};
               rx_word <= {rx_word[MAXB-2:0], sdo_s2_q};
               st_q    <= (cnt_q == 5'h00) ? dpsl_pkg::DPSL_DONE : dpsl_pkg::DPSL_LOW;
            end
            dpsl_pkg::DPSL_DONE: if (tick) begin
               cs_n_q <= 1'b1;
               busy   <= 1'b0;
               done   <= 1'b1;
               st_q   <= dpsl_pkg::DPSL_IDLE;
            end
            default: st_q <= dpsl_pkg::DPSL_IDLE;
         endcase
      end
   end
endmodule : dpsl_hst
`default_nettype wire

// file: bench/dpsl_assertions.sv
// Purpose: link-side checks on the serial wire
// Assumes: sck moves only inside frames
// Notes: preset low is the device reset
`timescale 1ns/1ps
`default_nettype none
module dpsl_assertions (
   input wire logic sck,
   input wire logic cs_n,
   input wire logic serial_data_in,
   input wire logic midscale_preset_n,
   input wire logic power_down_n,
   input wire logic chain_pd_en,
   input wire logic chain_data_out
);
   logic       pr;
   logic [3:0] shf_q;
   logic [4:0] frm_q;
   logic [1:0] lo_q;
   assign pr = ~midscale_preset_n;
   // rises since preset, held at nine
   always_ff @(posedge sck or negedge midscale_preset_n) begin
      if (!midscale_preset_n) shf_q <= 4'h0;
      else if (shf_q != 4'h9) shf_q <= shf_q + 4'h1;
   end
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) frm_q <= 5'h0;
      else frm_q <= frm_q + 5'h1;
   end
   always_ff @(negedge sck) lo_q <= {power_down_n, chain_pd_en};
   chk_chain_lag: assert property (@(posedge sck) disable iff (pr)
      shf_q == 4'h9 && power_down_n |-> chain_data_out == $past(serial_data_in, 9)) else $error("chain lag");
   chk_low_hold: assert property (@(posedge sck) disable iff (pr)
      shf_q != 4'h0 && lo_q[1] && power_down_n |-> chain_pd_en == lo_q[0]) else $error("low hold");
   chk_preset_clear: assert property (@(posedge sck) disable iff (pr)
      shf_q != 4'h9 && power_down_n |-> !chain_data_out) else $error("preset clear");
   chk_off_rise: assert property (@(posedge sck) disable iff (pr)
      !power_down_n |-> !chain_pd_en) else $error("off rise");
   chk_off_fall: assert property (@(negedge sck) disable iff (pr)
      !power_down_n |-> !chain_pd_en) else $error("off fall");
   chk_shift_framed: assert property (@(posedge sck) disable iff (pr)
      !cs_n) else $error("sck outside frame");
   chk_start_low: assert property (@(negedge cs_n) disable iff (pr)
      !sck) else $error("frame start");
   chk_frame_bits: assert property (@(posedge cs_n) disable iff (pr)
      frm_q != 5'h0 |-> frm_q inside {5'h9, 5'h10}) else $error("frame bits");
endmodule : dpsl_assertions
`default_nettype wire

// file: bench/digipot_serial_latch_control_test.sv
// Purpose: host and device ends joined
// Assumes: short sck half period
// Notes: dual channel device
`timescale 1ns/1ps
`default_nettype none
module digipot_serial_latch_control_test;
   logic mclk = 1'b0, rst_n = 1'b0, por_n = 1'b0, start = 1'b0, pre_n = 1'b0, shd_n = 1'b1;
   logic [17:0] word = 18'h0, rx_word;
   logic [4:0] nbits = 5'h0;
   logic busy, done, a_open, wiper_to_b;
   logic [7:0] wl0, wl1;
   logic [255:0] ts0, ts1;
   int failures = 0, samples_checked = 0;
   always #10 mclk = ~mclk;
   dpsl_if dpsl_if_i ();
   // three mclk per half period leaves room for the two-flop chain sampler
   dpsl_hst #(.HALF(3)) dpsl_hst_i (.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .lnk(dpsl_if_i.hst),
      .start(start), .word(word), .nbits(nbits), .preset_req_n(pre_n), .shutdown_req_n(shd_n),
      .busy(busy), .done(done), .rx_word(rx_word));
   dpsl_dev #(.CHANNELS(2)) dpsl_dev_i (.lnk(dpsl_if_i.dev), .por_n(por_n), .wiper_latch0(wl0),
      .wiper_latch1(wl1), .tap_sel0(ts0), .tap_sel1(ts1), .a_open(a_open), .wiper_to_b(wiper_to_b));
   dpsl_assertions dpsl_assertions_i (.sck(dpsl_if_i.sck), .cs_n(dpsl_if_i.cs_n),
      .serial_data_in(dpsl_if_i.serial_data_in), .midscale_preset_n(dpsl_if_i.midscale_preset_n),
      .power_down_n(dpsl_if_i.power_down_n), .chain_pd_en(dpsl_if_i.chain_pd_en),
      .chain_data_out(dpsl_if_i.chain_data_out));
   task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic lat(input logic [7:0] e0, input logic [7:0] e1);
      check("latch0", {10'h0, wl0}, {10'h0, e0});
      check("latch1", {10'h0, wl1}, {10'h0, e1});
      check("taps", {16'h0, ts0 === 256'h1 << e0, ts1 === 256'h1 << e1}, 18'h3);
   endtask : lat
   task automatic xfer(input logic [17:0] w, input logic [4:0] n);
      int k;
      @(posedge mclk);
      start <= 1'b1;
      word <= w;
      nbits <= n;
      @(posedge mclk);
      start <= 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 500) begin
         @(negedge mclk);
         k++;
      end
      check("done", {17'h0, done}, 18'h1);
   endtask : xfer
   task automatic test_done();
      if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   initial begin
      repeat (3000) @(posedge mclk);
      failures++;
      test_done();
   end
   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      pre_n <= 1'b1;
      repeat (4) @(posedge mclk);
      lat(8'h80, 8'h80);
      xfer(18'h03c, 5'h9);
      lat(8'h3c, 8'h80);
      xfer(18'h1c5, 5'h9);
      lat(8'h3c, 8'hc5);
      xfer(18'haaa7, 5'h10);
      lat(8'ha7, 8'hc5);
      shd_n <= 1'b0;
      repeat (4) @(posedge mclk);
      check("rx", {10'h0, rx_word[7:0]}, 18'haa);
      check("off", {16'h0, a_open, wiper_to_b}, 18'h3);
      xfer(18'h111, 5'h9);
      shd_n <= 1'b1;
      repeat (4) @(posedge mclk);
      check("off", {16'h0, a_open, wiper_to_b}, 18'h0);
      lat(8'ha7, 8'hc5);
      pre_n <= 1'b0;
      repeat (4) @(posedge mclk);
      lat(8'h80, 8'h80);
      pre_n <= 1'b1;
      repeat (4) @(posedge mclk);
      lat(8'h80, 8'h80);
      xfer(18'h1ff, 5'h9);
      xfer(18'h000, 5'h9);
      lat(8'h00, 8'hff);
      test_done();
   end
endmodule : digipot_serial_latch_control_test
`default_nettype wire
